// [shared/lfm_params.svh]
`ifndef LFM_PARAMS_SVH
`define LFM_PARAMS_SVH

// register numbers; byte address is four times the number
`define LFM_IDX_CHAN_LO      8'h30
`define LFM_IDX_GRID         8'h34
`define LFM_IDX_FCF_THZ      8'h35
`define LFM_IDX_FCF_GHZ10    8'h36
`define LFM_IDX_CUR_THZ      8'h40
`define LFM_IDX_CUR_GHZ10    8'h41
`define LFM_IDX_PWR          8'h42
`define LFM_IDX_TEMP         8'h43
`define LFM_IDX_FINE_TUNE    8'h62
`define LFM_IDX_CHAN_HI      8'h65
`define LFM_IDX_GRID_FINE    8'h66
`define LFM_IDX_FCF_MHZ      8'h67
`define LFM_IDX_CUR_MHZ      8'h68
`define LFM_IDX_CTRL         8'h70
`define LFM_IDX_RSP          8'h71
`define LFM_IDX_IRQ_STAT     8'h72
`define LFM_IDX_IRQ_CLR      8'h73
`define LFM_IDX_IRQ_EN       8'h74

// reset contents; first-channel values are maker defaults, arbitrary here
`define LFM_RST_FCF_THZ      16'h00C2
`define LFM_RST_FCF_GHZ10    16'h06D7
`define LFM_RST_FCF_MHZ      16'h0019
`define LFM_RST_GRID         16'h01F4
`define LFM_RST_CHAN_LO      16'h0001
`define LFM_RST_ZERO16       16'h0000
`define LFM_RST_IRQ          3'h0

// field limits
`define LFM_MAX_GHZ10        16'h270F
`define LFM_MAX_MHZ          16'h0063
`define LFM_MAX_GRID_FINE    16'sh0063
`define LFM_MIN_GRID_FINE    16'shFF9D
`define LFM_MAX_THZ          16'hFFFF

// unit factors
`define LFM_MHZ_PER_THZ      20'hF4240
`define LFM_MHZ_PER_GHZ10    7'h64

// field positions
`define LFM_CTRL_EN_BIT      0
`define LFM_IRQ_WR_ERR       0
`define LFM_IRQ_RD_ERR       1
`define LFM_IRQ_FREQ_DONE    2
`define LFM_RSP_XE_BIT       0
`define LFM_RSP_ERR_LSB      4
`define LFM_RSP_DATA_LSB     16

`endif

// [shared/lfm_pkg.sv]
package lfm_pkg;

   typedef enum logic [3:0] {
      ERR_NONE,
      NOT_WRITEABLE_ERR,
      CMD_PENDING_ERR,
      CMD_IGNORED_ERR,
      RUN_FAULT_ERR,
      VENDOR_DEFINED_ERR
   } lfm_err_cond_t;

   typedef enum logic [1:0] {
      ST_IDLE,
      ST_SUM,
      ST_DIV_THZ,
      ST_DIV_GHZ
   } lfm_calc_state_t;

endpackage

// [hdl/lfm_freq_sum.sv]
`timescale 1ns/1ps
`include "lfm_params.svh"
module lfm_freq_sum (
   input  wire logic        clk,          // system clock
   input  wire logic        reset_n,      // sync reset, active low
   input  wire logic        start,        // take operands this cycle
   input  wire logic [15:0] chan_lo,      // channel number low half
   input  wire logic [15:0] chan_hi,      // channel number high half
   input  wire logic [15:0] grid,         // grid spacing, GHz*10, signed
   input  wire logic [15:0] grid_fine,    // grid spacing, MHz, signed
   input  wire logic [15:0] fcf_thz,      // first channel THz
   input  wire logic [15:0] fcf_ghz10,    // first channel GHz*10
   input  wire logic [15:0] fcf_mhz,      // first channel MHz
   input  wire logic [15:0] fine_tune,    // fine tune MHz, signed
   output logic      [39:0] total_mhz,    // frequency in MHz, clamped
   output logic             valid         // one-cycle pulse with total
);
   logic signed [63:0] chan_m1;
   logic signed [63:0] grid_mhz;
   logic signed [63:0] fcf_total;
   logic signed [63:0] sum;
   logic        [39:0] total_d;
   logic        [39:0] total_q;
   logic               valid_q;

   // channel = high*65536 + low, all in MHz to stay integer
   assign chan_m1   = $signed({32'h0, chan_hi, chan_lo}) - 64'sd1;
   assign grid_mhz  = 64'($signed(grid)) * 64'($signed({1'b0, `LFM_MHZ_PER_GHZ10}))
                    + 64'($signed(grid_fine));
   assign fcf_total = $signed({48'h0, fcf_thz}) * $signed({44'h0, `LFM_MHZ_PER_THZ})
                    + $signed({48'h0, fcf_ghz10}) * $signed({57'h0, `LFM_MHZ_PER_GHZ10})
                    + $signed({48'h0, fcf_mhz});
   assign sum       = chan_m1 * grid_mhz + fcf_total + 64'($signed(fine_tune));
   // a negative result has no meaning as a frequency, so it reads as zero
   assign total_d   = sum[63] ? 40'h0 :
                      (|sum[62:40]) ? 40'hFF_FFFF_FFFF : sum[39:0];

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         total_q <= 40'h0;
         valid_q <= 1'b0;
      end else begin
         if (start) begin
            total_q <= total_d;
         end
         valid_q <= start;
      end
   end

   assign total_mhz = total_q;
   assign valid     = valid_q;
endmodule

// [hdl/lfm_divider.sv]
`timescale 1ns/1ps
module lfm_divider #(
   parameter int NW = 40,                 // dividend width
   parameter int DW = 20                  // divisor width
) (
   input  wire logic          clk,        // system clock
   input  wire logic          reset_n,    // sync reset, active low
   input  wire logic          start,      // load operands
   input  wire logic [NW-1:0] num,        // dividend
   input  wire logic [DW-1:0] den,        // divisor, nonzero
   output logic      [NW-1:0] quo,        // quotient
   output logic      [DW-1:0] rem,        // remainder
   output logic               done        // one-cycle pulse when finished
);
   localparam int CW = $clog2(NW + 1);
   logic [NW-1:0] quo_q;
   logic [DW-1:0] rem_q;
   logic [CW-1:0] cnt_q;
   logic          done_q;
   logic [DW:0]   shifted;
   logic [DW:0]   diff;

   // restoring division, one quotient bit per clock
   assign shifted = {rem_q, quo_q[NW-1]};
   assign diff    = shifted - {1'b0, den};

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         quo_q  <= '0;
         rem_q  <= '0;
         cnt_q  <= '0;
         done_q <= 1'b0;
      end else if (start) begin
         quo_q  <= num;
         rem_q  <= '0;
         cnt_q  <= CW'(NW);
         done_q <= 1'b0;
      end else if (cnt_q != '0) begin
         rem_q  <= diff[DW] ? shifted[DW-1:0] : diff[DW-1:0];
         quo_q  <= {quo_q[NW-2:0], ~diff[DW]};
         cnt_q  <= cnt_q - CW'(1);
         done_q <= (cnt_q == CW'(1));
      end else begin
         done_q <= 1'b0;
      end
   end

   assign quo  = quo_q;
   assign rem  = rem_q;
   assign done = done_q;
endmodule

// [hdl/lfm_regs.sv]
// Our own choice: register access over AHB-Lite.
`timescale 1ns/1ps
`include "lfm_params.svh"
// Contract
// - first frequency is THz plus GHz*10 plus MHz
// - GHz*10 field 0..9999, MHz field 0..99
// - THz range and defaults are maker choice
// - frequency = (channel-1)*grid + first + fine tune
// - current frequency read as three parts
// - frequency readable whether output enabled or not
// - reported GHz*10 within 0..9999, MHz 0..99
// - failed read gives error status, data zero
// - output power estimate readable as signed value
// - control temperature readable as signed value
// - first-frequency writes refused while output enabled
// - first-frequency writes in any order, no aggregate check
module lfm_regs (
   input  wire logic                SYS_CLK,    // 25 MHz system clock
   input  wire logic                RESET_N,    // sync reset, active low
   input  wire logic                HSEL,       // slave select
   input  wire logic [31:0]         HADDR,      // byte address
   input  wire logic [1:0]          HTRANS,     // transfer type
   input  wire logic                HWRITE,     // write when high
   input  wire logic [2:0]          HSIZE,      // word transfers only
   input  wire logic [31:0]         HWDATA,     // write data
   input  wire logic                HREADY,     // bus ready
   output logic      [31:0]         HRDATA,     // read data
   output logic                     HREADYOUT,  // always ready
   output logic                     HRESP,      // always OKAY
   input  wire logic [15:0]         PWR_EST,    // power estimate, dBm*100
   input  wire logic [15:0]         TEMP_EST,   // temperature, degC*100
   output logic                     LASER_EN,   // optical output enable
   output logic                     IRQ         // level interrupt
);
   import lfm_pkg::*;

   ////////////////////////////////////////////////////////////////////////////////
   // bus address phase

   logic [7:0]    dp_idx_q;
   logic          dp_wr_q;
   logic          dp_rd_q;
   logic          rd_err_q;
   logic [31:0]   hrdata_q;
   logic [31:0]   rd_val;
   logic          rd_hit;
   logic [15:0]   fcf_thz_q;
   logic [15:0]   fcf_ghz10_q;
   logic [15:0]   fcf_mhz_q;
   logic [15:0]   grid_q;
   logic [15:0]   grid_fine_q;
   logic [15:0]   chan_lo_q;
   logic [15:0]   chan_hi_q;
   logic [15:0]   fine_tune_q;
   logic [15:0]   cur_thz_q;
   logic [15:0]   cur_ghz10_q;
   logic [15:0]   cur_mhz_q;
   logic          laser_en_q;
   logic          rsp_xe_q;
   lfm_err_cond_t rsp_err_q;
   logic [15:0]   rsp_data_q;
   logic [2:0]    irq_stat_q;
   logic [2:0]    irq_en_q;

   wire       addr_take = HSEL & HTRANS[1] & HREADY;
   wire [7:0] a_idx     = HADDR[9:2];
   wire       a_aligned = (HADDR[31:10] == 22'h0) & (HADDR[1:0] == 2'h0);

   // zero-wait slave: every reply is settled within the data phase
   assign HREADYOUT = 1'b1;
   assign HRESP     = 1'b0;

   always_comb begin
      rd_val = 32'h0;
      rd_hit = a_aligned;
      unique case (a_idx)
         `LFM_IDX_FCF_THZ:   rd_val = {16'h0, fcf_thz_q};
         `LFM_IDX_FCF_GHZ10: rd_val = {16'h0, fcf_ghz10_q};
         `LFM_IDX_FCF_MHZ:   rd_val = {16'h0, fcf_mhz_q};
         `LFM_IDX_GRID:      rd_val = {16'h0, grid_q};
         `LFM_IDX_GRID_FINE: rd_val = {16'h0, grid_fine_q};
         `LFM_IDX_CHAN_LO:   rd_val = {16'h0, chan_lo_q};
         `LFM_IDX_CHAN_HI:   rd_val = {16'h0, chan_hi_q};
         `LFM_IDX_FINE_TUNE: rd_val = {16'h0, fine_tune_q};
         `LFM_IDX_CUR_THZ:   rd_val = {16'h0, cur_thz_q};
         `LFM_IDX_CUR_GHZ10: rd_val = {16'h0, cur_ghz10_q};
         `LFM_IDX_CUR_MHZ:   rd_val = {16'h0, cur_mhz_q};
         `LFM_IDX_PWR:       rd_val = {16'h0, PWR_EST};
         `LFM_IDX_TEMP:      rd_val = {16'h0, TEMP_EST};
         `LFM_IDX_CTRL:      rd_val = {31'h0, laser_en_q};
         `LFM_IDX_RSP:       rd_val = {rsp_data_q, 8'h0, rsp_err_q, 3'h0, rsp_xe_q};
         `LFM_IDX_IRQ_STAT:  rd_val = {29'h0, irq_stat_q};
         `LFM_IDX_IRQ_CLR:   rd_val = 32'h0;
         `LFM_IDX_IRQ_EN:    rd_val = {29'h0, irq_en_q};
         default:            rd_hit = 1'b0;
      endcase
   end

   // read data is caught at the address phase so it stands from a flop
   always_ff @(posedge SYS_CLK) begin
      if (!RESET_N) begin
         dp_idx_q <= 8'h00;
         dp_wr_q  <= 1'b0;
         dp_rd_q  <= 1'b0;
         rd_err_q <= 1'b0;
         hrdata_q <= 32'h0;
      end else begin
         dp_wr_q <= addr_take & HWRITE & a_aligned;
         dp_rd_q <= addr_take & ~HWRITE;
         if (addr_take) begin
            dp_idx_q <= a_aligned ? a_idx : 8'hFF;
         end
         if (addr_take & ~HWRITE) begin
            hrdata_q <= rd_hit ? rd_val : 32'h0;
            rd_err_q <= ~rd_hit;
         end
      end
   end

   assign HRDATA = hrdata_q;

   ////////////////////////////////////////////////////////////////////////////////
   // write data phase checks

   function automatic logic is_locked(input logic [7:0] idx);
      return (idx == `LFM_IDX_FCF_THZ) || (idx == `LFM_IDX_FCF_GHZ10) ||
             (idx == `LFM_IDX_FCF_MHZ) || (idx == `LFM_IDX_GRID) ||
             (idx == `LFM_IDX_GRID_FINE);
   endfunction

   function automatic logic is_calc_input(input logic [7:0] idx);
      return is_locked(idx) || (idx == `LFM_IDX_CHAN_LO) ||
             (idx == `LFM_IDX_CHAN_HI) || (idx == `LFM_IDX_FINE_TUNE);
   endfunction

   function automatic logic is_readback(input logic [7:0] idx);
      return (idx == `LFM_IDX_CUR_THZ) || (idx == `LFM_IDX_CUR_GHZ10) ||
             (idx == `LFM_IDX_CUR_MHZ) || (idx == `LFM_IDX_PWR) ||
             (idx == `LFM_IDX_TEMP) || (idx == `LFM_IDX_RSP) ||
             (idx == `LFM_IDX_IRQ_STAT);
   endfunction

   wire [15:0] wd       = HWDATA[15:0];
   wire        w_known  = is_calc_input(dp_idx_q) || is_readback(dp_idx_q) ||
                          (dp_idx_q == `LFM_IDX_CTRL) || (dp_idx_q == `LFM_IDX_IRQ_CLR) ||
                          (dp_idx_q == `LFM_IDX_IRQ_EN);
   // each field is checked alone; a combination that is not yet a valid
   // frequency is accepted so the three parts can be written in any order
   wire        w_range  = ((dp_idx_q == `LFM_IDX_FCF_GHZ10) && (wd > `LFM_MAX_GHZ10)) ||
                          ((dp_idx_q == `LFM_IDX_FCF_MHZ) && (wd > `LFM_MAX_MHZ)) ||
                          ((dp_idx_q == `LFM_IDX_GRID_FINE) &&
                           (($signed(wd) > `LFM_MAX_GRID_FINE) ||
                            ($signed(wd) < `LFM_MIN_GRID_FINE)));
   wire        w_lock   = is_locked(dp_idx_q) & laser_en_q;
   wire lfm_err_cond_t w_err = ~w_known                 ? VENDOR_DEFINED_ERR :
                               is_readback(dp_idx_q)    ? NOT_WRITEABLE_ERR :
                               (w_lock | w_range)       ? RUN_FAULT_ERR : ERR_NONE;
   wire        wr_ok    = dp_wr_q & (w_err == ERR_NONE);
   wire        wr_fail  = dp_wr_q & (w_err != ERR_NONE);
   wire        rd_fail  = dp_rd_q & rd_err_q;

   function automatic logic wr_to(input logic ok, input logic [7:0] cur,
                                  input logic [7:0] idx);
      return ok && (cur == idx);
   endfunction

   ////////////////////////////////////////////////////////////////////////////////
   // configuration registers

   always_ff @(posedge SYS_CLK) begin
      if (!RESET_N) begin
         fcf_thz_q   <= `LFM_RST_FCF_THZ;
         fcf_ghz10_q <= `LFM_RST_FCF_GHZ10;
         fcf_mhz_q   <= `LFM_RST_FCF_MHZ;
         grid_q      <= `LFM_RST_GRID;
         grid_fine_q <= `LFM_RST_ZERO16;
         chan_lo_q   <= `LFM_RST_CHAN_LO;
         chan_hi_q   <= `LFM_RST_ZERO16;
         fine_tune_q <= `LFM_RST_ZERO16;
         laser_en_q  <= 1'b0;
         irq_en_q    <= `LFM_RST_IRQ;
      end else begin
         if (wr_to(wr_ok, dp_idx_q, `LFM_IDX_FCF_THZ))   fcf_thz_q   <= wd;
         if (wr_to(wr_ok, dp_idx_q, `LFM_IDX_FCF_GHZ10)) fcf_ghz10_q <= wd;
         if (wr_to(wr_ok, dp_idx_q, `LFM_IDX_FCF_MHZ))   fcf_mhz_q   <= wd;
         if (wr_to(wr_ok, dp_idx_q, `LFM_IDX_GRID))      grid_q      <= wd;
         if (wr_to(wr_ok, dp_idx_q, `LFM_IDX_GRID_FINE)) grid_fine_q <= wd;
         if (wr_to(wr_ok, dp_idx_q, `LFM_IDX_CHAN_LO))   chan_lo_q   <= wd;
         if (wr_to(wr_ok, dp_idx_q, `LFM_IDX_CHAN_HI))   chan_hi_q   <= wd;
         if (wr_to(wr_ok, dp_idx_q, `LFM_IDX_FINE_TUNE)) fine_tune_q <= wd;
         if (wr_to(wr_ok, dp_idx_q, `LFM_IDX_CTRL))      laser_en_q  <= wd[`LFM_CTRL_EN_BIT];
         if (wr_to(wr_ok, dp_idx_q, `LFM_IDX_IRQ_EN))    irq_en_q    <= wd[2:0];
      end
   end

   assign LASER_EN = laser_en_q;

   ////////////////////////////////////////////////////////////////////////////////
   // response record and interrupts

   // reading the record itself leaves it alone, else it could never be seen
   wire rsp_upd = (dp_wr_q | dp_rd_q) & (dp_idx_q != `LFM_IDX_RSP);

   always_ff @(posedge SYS_CLK) begin
      if (!RESET_N) begin
         rsp_xe_q   <= 1'b0;
         rsp_err_q  <= ERR_NONE;
         rsp_data_q <= `LFM_RST_ZERO16;
      end else if (rsp_upd) begin
         rsp_xe_q   <= wr_fail | rd_fail;
         rsp_err_q  <= dp_wr_q ? w_err : (rd_err_q ? VENDOR_DEFINED_ERR : ERR_NONE);
         rsp_data_q <= dp_wr_q ? (wr_ok ? wd : 16'h0000) : hrdata_q[15:0];
      end
   end

   logic       freq_done;
   wire  [2:0] irq_set = {freq_done, rd_fail, wr_fail};
   wire  [2:0] irq_clr = wr_to(wr_ok, dp_idx_q, `LFM_IDX_IRQ_CLR) ? wd[2:0] : 3'h0;

   // a new event outranks a clear landing in the same cycle
   always_ff @(posedge SYS_CLK) begin
      if (!RESET_N) begin
         irq_stat_q <= `LFM_RST_IRQ;
      end else begin
         irq_stat_q <= (irq_stat_q & ~irq_clr) | irq_set;
      end
   end

   assign IRQ = |(irq_stat_q & irq_en_q);

   ////////////////////////////////////////////////////////////////////////////////
   // current frequency calculation

   lfm_calc_state_t state_q;
   logic            dirty_q;
   logic            sum_start;
   logic            div_thz_start;
   logic            div_ghz_start;
   logic [39:0]     total_mhz;
   logic            sum_valid;
   logic [39:0]     thz_quo;
   logic [19:0]     thz_rem;
   logic            thz_done;
   logic [19:0]     ghz_quo;
   logic [6:0]      ghz_rem;
   logic            ghz_done;
   logic [15:0]     thz_hold_q;

   assign sum_start     = (state_q == ST_IDLE) & dirty_q;
   assign div_thz_start = (state_q == ST_SUM) & sum_valid;
   assign div_ghz_start = (state_q == ST_DIV_THZ) & thz_done;
   assign freq_done     = (state_q == ST_DIV_GHZ) & ghz_done;

   lfm_freq_sum u_sum (
      .clk       (SYS_CLK),
      .reset_n   (RESET_N),
      .start     (sum_start),
      .chan_lo   (chan_lo_q),
      .chan_hi   (chan_hi_q),
      .grid      (grid_q),
      .grid_fine (grid_fine_q),
      .fcf_thz   (fcf_thz_q),
      .fcf_ghz10 (fcf_ghz10_q),
      .fcf_mhz   (fcf_mhz_q),
      .fine_tune (fine_tune_q),
      .total_mhz (total_mhz),
      .valid     (sum_valid)
   );

   lfm_divider #(.NW(40), .DW(20)) u_div_thz (
      .clk     (SYS_CLK),
      .reset_n (RESET_N),
      .start   (div_thz_start),
      .num     (total_mhz),
      .den     (`LFM_MHZ_PER_THZ),
      .quo     (thz_quo),
      .rem     (thz_rem),
      .done    (thz_done)
   );

   // remainder by 100 keeps the two low fields inside their ranges
   lfm_divider #(.NW(20), .DW(7)) u_div_ghz (
      .clk     (SYS_CLK),
      .reset_n (RESET_N),
      .start   (div_ghz_start),
      .num     (thz_rem),
      .den     (`LFM_MHZ_PER_GHZ10),
      .quo     (ghz_quo),
      .rem     (ghz_rem),
      .done    (ghz_done)
   );

   // a write during a running pass marks it dirty again; the pass in flight
   // still finishes, so readers always see a complete, consistent triple
   always_ff @(posedge SYS_CLK) begin
      if (!RESET_N) begin
         dirty_q <= 1'b1;
      end else begin
         dirty_q <= (dirty_q & ~sum_start) | (wr_ok & is_calc_input(dp_idx_q));
      end
   end

   always_ff @(posedge SYS_CLK) begin
      if (!RESET_N) begin
         state_q <= ST_IDLE;
      end else begin
         unique case (state_q)
            ST_IDLE:    if (sum_start)     state_q <= ST_SUM;
            ST_SUM:     if (sum_valid)     state_q <= ST_DIV_THZ;
            ST_DIV_THZ: if (thz_done)      state_q <= ST_DIV_GHZ;
            ST_DIV_GHZ: if (ghz_done)      state_q <= ST_IDLE;
         endcase
      end
   end

   always_ff @(posedge SYS_CLK) begin
      if (!RESET_N) begin
         thz_hold_q  <= `LFM_RST_ZERO16;
         cur_thz_q   <= `LFM_RST_ZERO16;
         cur_ghz10_q <= `LFM_RST_ZERO16;
         cur_mhz_q   <= `LFM_RST_ZERO16;
      end else begin
         if (div_ghz_start) begin
            thz_hold_q <= (|thz_quo[39:16]) ? `LFM_MAX_THZ : thz_quo[15:0];
         end
         if (freq_done) begin
            cur_thz_q   <= thz_hold_q;
            cur_ghz10_q <= {2'h0, ghz_quo[13:0]};
            cur_mhz_q   <= {9'h0, ghz_rem};
         end
      end
   end
endmodule

// [tb/lfm_regs_asserts.sv]
`timescale 1ns/1ps
module lfm_regs_chk (
   input  wire logic        SYS_CLK,    // system clock
   input  wire logic        RESET_N,    // sync reset, active low
   input  wire logic        HSEL,       // slave select
   input  wire logic [31:0] HADDR,      // byte address
   input  wire logic [1:0]  HTRANS,     // transfer type
   input  wire logic        HWRITE,     // write when high
   input  wire logic        HREADY,     // bus ready
   input  wire logic [31:0] HRDATA,     // read data
   input  wire logic        HREADYOUT,  // slave ready
   input  wire logic        HRESP,      // slave response
   input  wire logic [15:0] PWR_EST,    // power estimate
   input  wire logic [15:0] TEMP_EST,   // temperature
   input  wire logic        LASER_EN    // optical output enable
);
   ////////////////////////////////////////////////////////////
   wire       tk = HSEL & HTRANS[1] & HREADY;
   wire       wt = tk & HWRITE;
   // misaligned or high addresses read zero, so keep them out of value checks
   wire       rd = tk & ~HWRITE & (HADDR[31:10] == 22'h0) & (HADDR[1:0] == 2'h0);
   wire [7:0] ix = HADDR[9:2];
   default clocking cb @(posedge SYS_CLK); endclocking
   default disable iff (!RESET_N);
   ////////////////////////////////////////////////////////////
   a_bus_okay: assert property (HREADYOUT && !HRESP)
      else $error("bus answer not ready or not okay");
   a_rdata_hold: assert property (!(tk && !HWRITE) |=> $stable(HRDATA))
      else $error("read data moved without a read");
   a_power_live: assert property (rd && ix == 8'h42 |=> HRDATA == {16'h0, $past(PWR_EST)})
      else $error("power read wrong");
   a_temp_live: assert property (rd && ix == 8'h43 |=> HRDATA == {16'h0, $past(TEMP_EST)})
      else $error("temperature read wrong");
   a_ghz_range: assert property (rd && ix == 8'h41 |=> HRDATA <= 32'h0000270F)
      else $error("tenth gigahertz field out of range");
   a_mhz_range: assert property (rd && ix == 8'h68 |=> HRDATA <= 32'h00000063)
      else $error("megahertz field out of range");
   a_unmapped_zero: assert property (rd && ix inside {[8'h44:8'h61]} |=> HRDATA == 32'h0)
      else $error("unmapped read gave data");
   a_enable_cause: assert property ($changed(LASER_EN) |-> $past(wt, 2))
      else $error("output enable moved without a write");
endmodule
bind lfm_regs lfm_regs_chk chk_u (.SYS_CLK(SYS_CLK), .RESET_N(RESET_N), .HSEL(HSEL),
   .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE), .HREADY(HREADY), .HRDATA(HRDATA),
   .HREADYOUT(HREADYOUT), .HRESP(HRESP), .PWR_EST(PWR_EST), .TEMP_EST(TEMP_EST),
   .LASER_EN(LASER_EN));

// [tb/lfm_host_model.sv]
`timescale 1ns/1ps
module lfm_host_model (
   input  wire logic        clk,     // system clock
   input  wire logic        hready,  // bus ready
   input  wire logic [31:0] hrdata,  // read data
   output logic             hsel,    // slave select
   output logic      [31:0] haddr,   // byte address
   output logic      [1:0]  htrans,  // transfer type
   output logic             hwrite,  // write when high
   output logic      [2:0]  hsize,   // always a word
   output logic      [31:0] hwdata   // write data
);
   assign hsize = 3'h2;
   initial {hsel, haddr, htrans, hwrite, hwdata} = '0;
   ////////////////////////////////////////////////////////////
   // one single transfer; entered right after a rising edge, no pipelining
   task automatic xfer(input logic w, input logic [7:0] i, input logic [15:0] d,
                       output logic [31:0] q);
      int n = 0;
      hsel <= 1'b1;
      htrans <= 2'h2;
      hwrite <= w;
      haddr <= {22'h0, i, 2'h0};
      do begin
         @(posedge clk);
         n++;
      end while (hready !== 1'b1 && n < 16);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= {16'h0, d};
      do begin
         @(posedge clk);
         n++;
      end while (hready !== 1'b1 && n < 32);
      q = hrdata;
      if (hready !== 1'b1) tb.conclude(1'b1);
   endtask
endmodule

// [tb/tb.sv]
`timescale 1ns/1ps
module tb;
   logic        sys_clk, reset_n, hsel, hwrite, hreadyout, hresp, laser_en, irq;
   logic [1:0]  htrans;
   logic [2:0]  hsize;
   logic [15:0] pwr_est, temp_est;
   logic [31:0] haddr, hwdata, hrdata, q;
   int          mismatches, compares;
   lfm_regs dut_u (.SYS_CLK(sys_clk), .RESET_N(reset_n), .HSEL(hsel), .HADDR(haddr),
      .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(hsize), .HWDATA(hwdata), .HREADY(hreadyout),
      .HRDATA(hrdata), .HREADYOUT(hreadyout), .HRESP(hresp), .PWR_EST(pwr_est),
      .TEMP_EST(temp_est), .LASER_EN(laser_en), .IRQ(irq));
   lfm_host_model host_u (.clk(sys_clk), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));
   ////////////////////////////////////////////////////////////
   task automatic cmp(input logic [31:0] g, input logic [31:0] e);
      compares++;
      if (g !== e) begin
         mismatches++;
         $display("mismatch at %0t: got %h expected %h", $time, g, e);
      end
   endtask
   task automatic rchk(input logic [7:0] i, input logic [31:0] e);
      logic [31:0] d;
      host_u.xfer(1'b0, i, 16'h0, d);
      cmp(d, e);
   endtask
   // err 0 expects the echoed value, otherwise the error code with the failure bit
   task automatic wchk(input logic [7:0] i, input logic [15:0] v, input logic [3:0] err);
      host_u.xfer(1'b1, i, v, q);
      rchk(8'h71, (err == 4'h0) ? {v, 16'h0} : {24'h0, err, 4'h1});
   endtask
   // pins sampled at the falling edge so the write edge has settled
   task automatic pchk(input logic [1:0] e);
      @(negedge sys_clk);
      cmp({30'h0, laser_en, irq}, {30'h0, e});
      @(posedge sys_clk);
   endtask
   // clear the update flag, then poll it; a pass takes about 63 cycles
   task automatic settle;
      int n = 0;
      host_u.xfer(1'b1, 8'h73, 16'h4, q);
      do begin
         host_u.xfer(1'b0, 8'h72, 16'h0, q);
         n++;
      end while (q[2] !== 1'b1 && n < 60);
      if (q[2] !== 1'b1) conclude(1'b1);
   endtask
   task automatic conclude(input logic tmo);
      if (tmo) begin
         mismatches++;
         $display("mismatch at %0t: wait ran out", $time);
      end
      $display("compares %0d mismatches %0d", compares, mismatches);
      if (mismatches == 0 && compares > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////
   initial begin
      sys_clk = 1'b0;
      forever #20 sys_clk = ~sys_clk;
   end
   initial begin
      reset_n = 1'b0;
      pwr_est = 16'hFF38;
      temp_est = 16'h0BB8;
      mismatches = 0;
      compares = 0;
      repeat (16) @(posedge sys_clk);
      reset_n <= 1'b1;
      rchk(8'h35, 32'hC2);
      rchk(8'h36, 32'h6D7);
      rchk(8'h67, 32'h19);
      settle();
      rchk(8'h40, 32'hC2);
      rchk(8'h41, 32'h6D7);
      rchk(8'h68, 32'h19);
      $display("test reset done");
      wchk(8'h35, 16'h0, 4'h0);
      wchk(8'h36, 16'h2710, 4'h4);
      wchk(8'h67, 16'h64, 4'h4);
      wchk(8'h67, 16'h32, 4'h0);
      wchk(8'h36, 16'h3E8, 4'h0);
      wchk(8'h35, 16'hC1, 4'h0);
      wchk(8'h30, 16'h3, 4'h0);
      wchk(8'h62, 16'h7, 4'h0);
      // the pass started by the first write still ends with old operands;
      // only the re-queued pass after it carries the full set
      settle();
      settle();
      rchk(8'h40, 32'hC1);
      rchk(8'h41, 32'h7D0);
      rchk(8'h68, 32'h39);
      rchk(8'h71, 32'h00390000);
      $display("test frequency done");
      wchk(8'h40, 16'h5, 4'h1);
      wchk(8'h43, 16'h5, 4'h1);
      rchk(8'h42, 32'hFF38);
      rchk(8'h43, 32'hBB8);
      rchk(8'h44, 32'h0);
      rchk(8'h71, 32'h51);
      $display("test readback done");
      wchk(8'h70, 16'h1, 4'h0);
      pchk(2'b10);
      wchk(8'h36, 16'h5, 4'h4);
      rchk(8'h36, 32'h3E8);
      rchk(8'h40, 32'hC1);
      wchk(8'h70, 16'h0, 4'h0);
      $display("test enable done");
      rchk(8'h72, 32'h7);
      host_u.xfer(1'b1, 8'h74, 16'h1, q);
      pchk(2'b01);
      host_u.xfer(1'b1, 8'h73, 16'h1, q);
      pchk(2'b00);
      rchk(8'h72, 32'h6);
      rchk(8'h73, 32'h0);
      $display("test interrupt done");
      conclude(1'b0);
   end
endmodule
